// ---- verilog/mpi_defines.svh ----
`ifndef MPI_DEFINES_SVH
`define MPI_DEFINES_SVH

// Number of audio serial ports and shared serial source pins.
`define MPI_NUM_PORTS 3
`define MPI_NUM_PINS 7
`define MPI_SEL_W 3

// Source selector code that forces the mute input to zero.
`define MPI_SEL_ZERO 3'h0

// Event type numbers raised towards the CPU, one per port.
`define MPI_EVT_PORT0 5'h1a
`define MPI_EVT_PORT1 5'h1b
`define MPI_EVT_PORT2 5'h1c
`define MPI_EVT_W 5

// Least pulse width of the external source, in engine clock cycles.
`define MPI_MIN_PULSE_CYC 2

`endif

// ---- verilog/mpi_pkg.sv ----
`include "mpi_defines.svh"

package mpi_pkg;

	typedef logic [`MPI_SEL_W-1:0] mpi_sel_t;
	typedef logic [`MPI_NUM_PINS-1:0] mpi_pins_t;
	typedef logic [`MPI_EVT_W-1:0] mpi_evt_num_t;

	typedef struct packed
	{
		logic sync1;
		logic sync2;
		logic last;
		logic edge_evt;
	} mpi_det_state_t;

	typedef struct packed
	{
		logic [`MPI_NUM_PINS-1:0]  pin_sync1;
		logic [`MPI_NUM_PINS-1:0]  pin_sync2;
		logic [`MPI_NUM_PORTS-1:0] evt;
		logic [`MPI_NUM_PORTS-1:0] mute_level;
		logic [`MPI_NUM_PORTS-1:0] mute_drive;
	} mpi_top_state_t;

endpackage

// ---- verilog/mpi_edge_if.sv ----
`timescale 1ns/10ps

// Carries one selected mute level into the edge detector and its event back.
interface mpi_edge_if;
	logic level;
	logic edge_evt;
	logic sampled;

	modport top
	(
		output level,
		input  edge_evt,
		input  sampled
	);

	modport det
	(
		input  level,
		output edge_evt,
		output sampled
	);
endinterface

// ---- verilog/mpi_edge_det.sv ----
`timescale 1ns/10ps

// Synchronises one mute input and pulses on every change of its level.
module mpi_edge_det
	import mpi_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// Source and event
	mpi_edge_if.det   edge_if
);

	mpi_det_state_t state_reg;
	mpi_det_state_t state_next;

	always_comb
	begin
		state_next          = state_reg;
		state_next.sync1    = edge_if.level;
		state_next.sync2    = state_reg.sync1;
		state_next.last     = state_reg.sync2;
		// Both directions count; nothing is held beyond this cycle.
		state_next.edge_evt = state_reg.sync2 ^ state_reg.last;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign edge_if.edge_evt = state_reg.edge_evt;
	assign edge_if.sampled  = state_reg.sync2;

endmodule

// ---- verilog/mpi_mute_irq.sv ----
`timescale 1ns/10ps

// Overview of operation
// - Ports 0, 1 and 2 raise event types 26, 27 and 28 respectively.
// - Both rising and falling edges of the selected mute input are events.
// - A detected edge is never stored in a flag; it is a one-cycle pulse only.
// - Each port's mute event is ORed with its transmit and receive error events.
// - Selector code 000 forces zero; codes 001 to 111 pick one of seven pins.
// - Software clears the mute input enable so the mute output is not driven.
module mpi_mute_irq
	import mpi_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        srst_in,
	// Shared serial pins and per-port source selection
	input  wire logic [`MPI_NUM_PINS-1:0]    pins_in,
	input  wire logic [`MPI_SEL_W-1:0]       port0_mute_source_sel_in,
	input  wire logic [`MPI_SEL_W-1:0]       port1_mute_source_sel_in,
	input  wire logic [`MPI_SEL_W-1:0]       port2_mute_source_sel_in,
	// Port error events and mute control
	input  wire logic [`MPI_NUM_PORTS-1:0]   tx_err_evt_in,
	input  wire logic [`MPI_NUM_PORTS-1:0]   rx_err_evt_in,
	input  wire logic [`MPI_NUM_PORTS-1:0]   mute_input_enable_in,
	// Combined events towards the DMA accelerator, mute levels and mute output controls
	output logic      [`MPI_NUM_PORTS-1:0]   combined_error_event_out,
	output logic      [`MPI_NUM_PORTS-1:0]   mute_level_out,
	output logic      [`MPI_NUM_PORTS-1:0]   mute_output_control_out
);

	// Pins are raw asynchronous inputs, so each one passes two flip-flops before the mux reads it.
	// Selector changes are quasi-static and may cause one spurious event.
	mpi_top_state_t            state_reg;
	mpi_top_state_t            state_next;
	logic [`MPI_NUM_PORTS-1:0] det_evt;
	logic [`MPI_NUM_PORTS-1:0] det_lvl;

	// Picks the mute source; code zero gives a constant low.
	function automatic logic sel_source
	(
		input mpi_sel_t  sel,
		input mpi_pins_t pins
	);
		logic r;
		r = 1'b0;
		case (sel)
			`MPI_SEL_ZERO:
				r = 1'b0;
			3'h1:
				r = pins[0];
			3'h2:
				r = pins[1];
			3'h3:
				r = pins[2];
			3'h4:
				r = pins[3];
			3'h5:
				r = pins[4];
			3'h6:
				r = pins[5];
			3'h7:
				r = pins[6];
			default:
				r = 1'b0;
		endcase
		return r;
	endfunction

	// Merges one port's mute edge with its transmit and receive error events.
	function automatic logic combine_event
	(
		input logic mute_evt,
		input logic tx_evt,
		input logic rx_evt
	);
		logic r;
		r = mute_evt | tx_evt | rx_evt;
		return r;
	endfunction

	// The mute output follows the level only while its enable is set.
	function automatic logic gate_mute
	(
		input logic level,
		input logic enable
	);
		logic r;
		r = level & enable;
		return r;
	endfunction

	// Port 0 raises event type 26 on output bit 0.
	mpi_edge_if port0_if ();

	assign port0_if.level = sel_source(port0_mute_source_sel_in, state_reg.pin_sync2);
	assign det_evt[0]     = port0_if.edge_evt;
	assign det_lvl[0]     = port0_if.sampled;

	mpi_edge_det u_port0_det
	(
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.edge_if (port0_if)
	);

	// Port 1 raises event type 27 on output bit 1.
	mpi_edge_if port1_if ();

	assign port1_if.level = sel_source(port1_mute_source_sel_in, state_reg.pin_sync2);
	assign det_evt[1]     = port1_if.edge_evt;
	assign det_lvl[1]     = port1_if.sampled;

	mpi_edge_det u_port1_det
	(
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.edge_if (port1_if)
	);

	// Port 2 raises event type 28 on output bit 2.
	mpi_edge_if port2_if ();

	assign port2_if.level = sel_source(port2_mute_source_sel_in, state_reg.pin_sync2);
	assign det_evt[2]     = port2_if.edge_evt;
	assign det_lvl[2]     = port2_if.sampled;

	mpi_edge_det u_port2_det
	(
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.edge_if (port2_if)
	);

	always_comb
	begin
		state_next               = state_reg;
		state_next.pin_sync1     = pins_in;
		state_next.pin_sync2     = state_reg.pin_sync1;
		// Each port's mute edge is ORed with both error sources, never stored.
		state_next.evt[0]        = combine_event(det_evt[0], tx_err_evt_in[0], rx_err_evt_in[0]);
		state_next.evt[1]        = combine_event(det_evt[1], tx_err_evt_in[1], rx_err_evt_in[1]);
		state_next.evt[2]        = combine_event(det_evt[2], tx_err_evt_in[2], rx_err_evt_in[2]);
		state_next.mute_level    = det_lvl;
		// Mute output only follows the input while software keeps it enabled.
		state_next.mute_drive[0] = gate_mute(det_lvl[0], mute_input_enable_in[0]);
		state_next.mute_drive[1] = gate_mute(det_lvl[1], mute_input_enable_in[1]);
		state_next.mute_drive[2] = gate_mute(det_lvl[2], mute_input_enable_in[2]);
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign combined_error_event_out = state_reg.evt;
	assign mute_level_out           = state_reg.mute_level;
	assign mute_output_control_out  = state_reg.mute_drive;

endmodule

// ---- sim/mpi_pin_src.sv ----
`timescale 1ns/10ps
module mpi_pin_src
(
	// Pins towards the device
	input  wire logic       clk_in,
	output logic      [6:0] pins_out
);
	initial pins_out = 7'h00;
	task automatic flip(input int k, input int n);
		@(negedge clk_in) pins_out[k] = ~pins_out[k];
		repeat ((n < 2) ? 2 : n) @(negedge clk_in);
	endtask
endmodule

// ---- sim/mpi_mute_irq_monitor.sv ----
`timescale 1ns/10ps
module mpi_mute_irq_monitor
(
	// Watched ports
	input wire logic       clk_in,
	input wire logic       srst_in,
	input wire logic [2:0] tx_err_evt_in,
	input wire logic [2:0] rx_err_evt_in,
	input wire logic [2:0] combined_error_event_out,
	input wire logic [2:0] mute_level_out,
	input wire logic [2:0] port2_mute_source_sel_in,
	input wire logic [2:0] mute_input_enable_in,
	input wire logic [2:0] mute_output_control_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	property p_edge;
		$changed(mute_level_out[0]) |=> combined_error_event_out[0];
	endproperty
	a_edge: assert property (p_edge) else $error("edge lost");
	property p_err;
		tx_err_evt_in[1] || rx_err_evt_in[1] |=> combined_error_event_out[1];
	endproperty
	a_err: assert property (p_err) else $error("error lost");
	property p_cause;
		combined_error_event_out[2] |-> $past(tx_err_evt_in[2] || rx_err_evt_in[2])
			|| $past(mute_level_out[2]) != $past(mute_level_out[2], 2);
	endproperty
	a_cause: assert property (p_cause) else $error("event without cause");
	property p_sel_zero;
		(port2_mute_source_sel_in == 3'h0) [*6] |-> !mute_level_out[2];
	endproperty
	a_sel_zero: assert property (p_sel_zero) else $error("code zero not low");
	property p_mute;
		mute_output_control_out == (mute_level_out & $past(mute_input_enable_in));
	endproperty
	a_mute: assert property (p_mute) else $error("mute output not gated");
	property p_single;
		combined_error_event_out[0] && !$past(tx_err_evt_in[0] || rx_err_evt_in[0])
			|=> !combined_error_event_out[0] || $past(tx_err_evt_in[0] || rx_err_evt_in[0]);
	endproperty
	a_single: assert property (p_single) else $error("mute event held");
endmodule
bind mpi_mute_irq mpi_mute_irq_monitor i_mpi_mute_irq_monitor(.*);

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic       clk_in = 1'b0;
	logic       srst_in = 1'b1;
	logic [6:0] pins;
	logic [2:0] sel = 3'h0;
	logic [2:0] tx = 3'h0;
	logic [2:0] rx = 3'h0;
	logic [2:0] evt;
	logic [2:0] mo;
	logic [2:0] lvl;
	logic [2:0] en = 3'h1;
	logic [3:0] cnt;
	int         failures = 0;
	int         n_compared = 0;
	int         cyc = 0;
	always #12.5 clk_in = ~clk_in;
	mpi_pin_src i_mpi_pin_src(.clk_in(clk_in), .pins_out(pins));
	mpi_mute_irq i_mpi_mute_irq(.clk_in(clk_in), .srst_in(srst_in), .pins_in(pins),
		.port0_mute_source_sel_in(sel), .port1_mute_source_sel_in(sel), .port2_mute_source_sel_in(3'h0),
		.tx_err_evt_in(tx), .rx_err_evt_in(rx), .mute_input_enable_in(en),
		.combined_error_event_out(evt), .mute_level_out(lvl), .mute_output_control_out(mo));
	task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// Weighs each port's event by its bit so the port index shows in the sum.
	task automatic count();
		cnt = 4'h0;
		repeat (10) @(negedge clk_in) cnt += {1'b0, evt};
	endtask
	task automatic t_sel();
		for (int c = 0; c < 16; c++)
		begin
			sel = c[3:1];
			repeat (6) @(negedge clk_in);
			i_mpi_pin_src.flip((c / 2 + 6) % 7, 2);
			count();
			chk("events", (c < 2) ? 4'h0 : 4'h3, cnt);
			chk("mute", {3'h0, c > 1 && !c[0]}, {1'b0, mo});
			chk("level", {2'h0, {2{c > 1 && !c[0]}}}, {1'b0, lvl});
		end
		$display("select test done");
	endtask
	task automatic t_err();
		fork
			count();
			begin
				tx = 3'h2;
				rx = 3'h4;
				@(negedge clk_in) tx = 3'h0;
				repeat (2) @(negedge clk_in);
				rx = 3'h0;
			end
		join
		chk("errors", 4'he, cnt);
		$display("error test done");
	endtask
	task automatic stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_in)
		if (++cyc == 2000)
		begin
			failures++;
			stop_test();
		end
	initial
	begin
		repeat (12) @(negedge clk_in);
		srst_in = 1'b0;
		t_sel();
		t_err();
		stop_test();
	end
endmodule
